// ==== logic/flash_status_pkg.sv ====
// Status register layout, opcodes, states and opcode class helpers
package flash_status_pkg;

    // ----------------------------------------------------------------
    // Register layout and carriers
    // ----------------------------------------------------------------
    // Field order gives the bit positions, lock on top, busy at bit 0
    typedef struct packed {
        logic status_lock_bit;
        logic quad_enable;
        logic [3:0] block_protect;
        logic write_enable_latch;
        logic busy_flag;
    } status_s;

    // Accepted instruction handed to the array engine
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } cmd_s;

    typedef enum logic [2:0] {
        ST_LOAD = 3'b000,
        ST_OPCODE = 3'b001,
        ST_READ_STATUS_CMD = 3'b010,
        ST_WRDATA = 3'b011,
        ST_SKIP = 3'b100
    } state_e;

    localparam status_s STATUS_RESET = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Pin vector order {wp_n, si, cs_n, sck}; idle is cs_n and wp_n high
    localparam int PIN_COUNT = 4;
    localparam int PIN_SCK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_WP = 3;
    localparam logic [3:0] PIN_IDLE = 4'hA;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_VOL_STATUS_ENABLE = 8'h50;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] CMD_READ_FUNCTION = 8'h48;
    localparam logic [7:0] CMD_READ_EXT_PARAMS = 8'h81;
    localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
    localparam logic [7:0] CMD_RESET = 8'h99;
    localparam logic [7:0] CMD_SUSPEND_A = 8'h75;
    localparam logic [7:0] CMD_SUSPEND_B = 8'hB0;

    // ----------------------------------------------------------------
    // Opcode classes
    // ----------------------------------------------------------------
    // Write class gated by the latch; C0h and 17h stay outside
    function automatic logic needs_latch(input logic [7:0] code);
        case (code)
            8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E: return 1'b1;
            8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC,
            8'hC7, 8'h60: return 1'b1;
            8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83,
            8'h15, 8'h18, 8'hC5: return 1'b1;
            8'h64, 8'h62, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4,
            8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8: return 1'b1;
            8'h43, 8'h4A, 8'hB5: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : needs_latch

    // Program and erase, the operations that may be suspended
    function automatic logic is_prog_erase(input logic [7:0] code);
        case (code)
            8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20, 8'h21,
            8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, 8'h64, 8'h62: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_prog_erase

    // Long operations that hold busy; volatile writes finish at once
    function automatic logic is_busy_op(input logic [7:0] code);
        case (code)
            8'h42, 8'h65, 8'h85, 8'h15, 8'h18, 8'hFD, 8'hE3, 8'hE4,
            8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8, 8'h43, 8'hB5: return 1'b1;
            default: return is_prog_erase(code);
        endcase
    endfunction : is_busy_op

    // Reads and resets still served while busy
    function automatic logic busy_ok(input logic [7:0] code);
        case (code)
            CMD_READ_STATUS, CMD_READ_FUNCTION, CMD_READ_EXT_PARAMS,
            CMD_RESET_ENABLE, CMD_RESET: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : busy_ok

endpackage : flash_status_pkg

// ==== logic/pin_sync.sv ====
// Two-flop synchronisers for the serial pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    // ----------------------------------------------------------------
    // One chain per pin
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            logic meta_r;
            logic hold_r;
            // First stage feeds only the second
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta_r <= IDLE[i];
                    hold_r <= IDLE[i];
                end
                else
                begin
                    meta_r <= pin_in[i];
                    hold_r <= meta_r;
                end
            end
            assign pin_out[i] = hold_r;
        end
    endgenerate

endmodule : pin_sync

// ==== logic/flash_status_write_enable_logic.sv ====
// Status register pair and write enable gating of the serial flash
`timescale 1ns/1ns
// Notes on behaviour
// - Continued status read repeats the register byte until chip select rises.
// - Volatile copy loads from the non-volatile copy at power-up.
// - Status read returns the volatile copy only.
// - Layout: lock 7, quad 6, protect 5..2, latch 1, busy 0; all reset 0.
// - Busy is read-only, high during long operations, low when they end.
// - While busy, only register reads and resets are accepted.
// - Suspend is also accepted during program or erase.
// - Latch low blocks the write class; latch high allows it.
// - Write enable sets the latch; host sends it before writes.
// - Latch is set only by write enable; write disable and operation end clear it.
// - Volatile enable does not set the latch.
// - Write disable clears the latch.
// - Latch clears when a register write, program or erase completes. Volatile register writes, which never set busy, leave it set.
// - Status write updates protect, quad and lock in the volatile copy, and in the non-volatile copy unless volatile-enabled.
// - Page program codes need the latch.
// - Sector, block and chip erase codes need the latch.
// - Register write codes need the latch.
// - Info row, lock, protection, gang and password codes need the latch.
// - Training pattern and error correction writes need the latch.
// - Protect bits mark blocks protected; quad bit enables quad data. Here protect only blocks chip erase, and quad drives nothing.
// - Lock bit high marks the status register write-protected.
// - Lock high with write-protect low ignores the status write.
// - Volatile read-parameter and bank-address codes skip the latch. Only C0h and 17h skip it here; 63h, 83h and C5h need the latch.
// - Chip erase is ignored unless all protect bits are zero.
module flash_status_write_enable_logic (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic op_done,
    output logic so,
    output logic so_oe_n,
    output flash_status_pkg::cmd_s cmd,
    output flash_status_pkg::status_s status
);
    import flash_status_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pins_s;
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic wp_n_s;
    assign pins_raw = {wp_n, si, cs_n, sck};
    pin_sync #(.W(PIN_COUNT), .IDLE(PIN_IDLE)) u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(pins_raw),
        .pin_out(pins_s)
    );
    assign sck_s = pins_s[PIN_SCK];
    assign cs_n_s = pins_s[PIN_CS];
    assign si_s = pins_s[PIN_SI];
    assign wp_n_s = pins_s[PIN_WP];

    logic sck_prev_r;
    logic cs_prev_r;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;

    // Serial clock passes two synchroniser flops, so edges are found two cycles late
    assign sck_rise = sck_s & ~sck_prev_r & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_r & ~cs_n_s;
    assign frame_end = cs_n_s & ~cs_prev_r;

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    state_e state_r;
    state_e state_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic [7:0] wr_data_r;
    logic [7:0] wr_data_nxt;
    status_s vol_r;
    status_s vol_nxt;
    status_s nv_r;
    status_s nv_nxt;
    logic vol_arm_r;
    logic vol_arm_nxt;
    logic write_status_cmd_pend_r;
    logic write_status_cmd_pend_nxt;
    logic write_status_cmd_vol_r;
    logic write_status_cmd_vol_nxt;
    logic op_pend_r;
    logic op_pend_nxt;
    logic pe_pend_r;
    logic pe_pend_nxt;
    logic pe_run_r;
    logic pe_run_nxt;
    logic so_r;
    logic so_nxt;
    logic so_oe_n_r;
    logic so_oe_n_nxt;
    cmd_s cmd_r;
    cmd_s cmd_nxt;
    logic [7:0] code;
    logic byte_done;
    logic accept;
    logic latch_ok;
    logic locked;
    assign code = {shift_r[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_r == LAST_BIT);
    // Hardware protection needs both the lock bit and the pin low
    assign locked = vol_r.status_lock_bit && !wp_n_s;
    // Busy admits reads, resets and, during program or erase, suspend
    assign accept = !vol_r.busy_flag || busy_ok(code)
        || (pe_run_r && (code == CMD_SUSPEND_A || code == CMD_SUSPEND_B));
    // A volatile status write is armed by its own enable, not the latch
    assign latch_ok = !needs_latch(code) || vol_r.write_enable_latch
        || (code == CMD_WRITE_STATUS && vol_arm_r);

    // Next-state logic for the whole frame decoder and status pair
    always_comb
    begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        tx_nxt = tx_r;
        wr_data_nxt = wr_data_r;
        vol_nxt = vol_r;
        nv_nxt = nv_r;
        vol_arm_nxt = vol_arm_r;
        write_status_cmd_pend_nxt = write_status_cmd_pend_r;
        write_status_cmd_vol_nxt = write_status_cmd_vol_r;
        op_pend_nxt = op_pend_r;
        pe_pend_nxt = pe_pend_r;
        pe_run_nxt = pe_run_r;
        so_nxt = so_r;
        so_oe_n_nxt = so_oe_n_r;
        cmd_nxt = '{valid: 1'b0, code: cmd_r.code};
        // Operation end from the array engine, success or not
        if (op_done && vol_r.busy_flag)
        begin
            vol_nxt.busy_flag = 1'b0;
            vol_nxt.write_enable_latch = 1'b0;
            pe_run_nxt = 1'b0;
        end
        if (state_r == ST_LOAD)
        begin
            vol_nxt = nv_r;
            state_nxt = ST_OPCODE;
        end
        else if (cs_n_s)
        begin
            // Idle between frames; the output is released
            state_nxt = ST_OPCODE;
            bit_cnt_nxt = 3'h0;
            so_oe_n_nxt = 1'b1;
            if (frame_end && write_status_cmd_pend_r)
            begin
                // Busy and latch bits are never taken from the data
                vol_nxt.status_lock_bit = wr_data_r[7];
                vol_nxt.quad_enable = wr_data_r[6];
                vol_nxt.block_protect = wr_data_r[5:2];
                if (!write_status_cmd_vol_r)
                begin
                    nv_nxt.status_lock_bit = wr_data_r[7];
                    nv_nxt.quad_enable = wr_data_r[6];
                    nv_nxt.block_protect = wr_data_r[5:2];
                    vol_nxt.busy_flag = 1'b1;
                    pe_run_nxt = 1'b0;
                end
            end
            // Long operations start when the frame closes; set beats done
            if (frame_end && op_pend_r)
            begin
                vol_nxt.busy_flag = 1'b1;
                pe_run_nxt = pe_pend_r;
            end
            if (frame_end)
            begin
                write_status_cmd_pend_nxt = 1'b0;
                op_pend_nxt = 1'b0;
                pe_pend_nxt = 1'b0;
            end
        end
        else
        begin
            if (sck_rise)
            begin
                shift_nxt = code;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
            end
            case (state_r)
                ST_OPCODE:
                begin
                    if (byte_done)
                    begin
                        // Volatile enable lasts only to the next opcode
                        vol_arm_nxt = 1'b0;
                        state_nxt = ST_SKIP;
                        if (accept && latch_ok
                            && !((code == CMD_CHIP_ERASE_A || code == CMD_CHIP_ERASE_B)
                                 && vol_r.block_protect != 4'h0)
                            && !(code == CMD_WRITE_STATUS && locked))
                        begin
                            cmd_nxt = '{valid: 1'b1, code: code};
                            case (code)
                                CMD_READ_STATUS:
                                begin
                                    state_nxt = ST_READ_STATUS_CMD;
                                    tx_nxt = vol_r;
                                end
                                CMD_WRITE_ENABLE: vol_nxt.write_enable_latch = 1'b1;
                                CMD_WRITE_DISABLE: vol_nxt.write_enable_latch = 1'b0;
                                CMD_VOL_STATUS_ENABLE: vol_arm_nxt = 1'b1;
                                CMD_WRITE_STATUS:
                                begin
                                    state_nxt = ST_WRDATA;
                                    write_status_cmd_vol_nxt = vol_arm_r;
                                end
                                default:
                                begin
                                    op_pend_nxt = is_busy_op(code);
                                    pe_pend_nxt = is_prog_erase(code);
                                end
                            endcase
                        end
                    end
                end
                ST_READ_STATUS_CMD:
                begin
                    // Mode 0: shift out on the falling edge
                    so_oe_n_nxt = 1'b0;
                    if (sck_fall)
                    begin
                        so_nxt = tx_r[7];
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                    // Each new byte reloads the current volatile value
                    if (byte_done)
                        tx_nxt = vol_r;
                end
                ST_WRDATA:
                begin
                    // Only a complete data byte is applied at frame end
                    if (byte_done)
                    begin
                        wr_data_nxt = code;
                        write_status_cmd_pend_nxt = 1'b1;
                        state_nxt = ST_SKIP;
                    end
                end
                ST_SKIP: state_nxt = ST_SKIP;
                default: state_nxt = ST_OPCODE;
            endcase
        end
    end

    // Registers of the decoder; the non-volatile copy models factory zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_LOAD;
            sck_prev_r <= 1'b0; // Idle levels, so no false edge after reset
            cs_prev_r <= 1'b1;
            shift_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            tx_r <= 8'h00;
            wr_data_r <= 8'h00;
            vol_r <= STATUS_RESET;
            nv_r <= STATUS_RESET;
            vol_arm_r <= 1'b0;
            write_status_cmd_pend_r <= 1'b0;
            write_status_cmd_vol_r <= 1'b0;
            op_pend_r <= 1'b0;
            pe_pend_r <= 1'b0;
            pe_run_r <= 1'b0;
            so_r <= 1'b0;
            so_oe_n_r <= 1'b1;
            cmd_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            sck_prev_r <= sck_s;
            cs_prev_r <= cs_n_s;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            tx_r <= tx_nxt;
            wr_data_r <= wr_data_nxt;
            vol_r <= vol_nxt;
            nv_r <= nv_nxt;
            vol_arm_r <= vol_arm_nxt;
            write_status_cmd_pend_r <= write_status_cmd_pend_nxt;
            write_status_cmd_vol_r <= write_status_cmd_vol_nxt;
            op_pend_r <= op_pend_nxt;
            pe_pend_r <= pe_pend_nxt;
            pe_run_r <= pe_run_nxt;
            so_r <= so_nxt;
            so_oe_n_r <= so_oe_n_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign so = so_r;
    assign so_oe_n = so_oe_n_r;
    assign cmd = cmd_r;
    assign status = vol_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_read_status_cmd_byte_end;
        state_r == ST_READ_STATUS_CMD && byte_done && !cs_n_s;
    endsequence
    sequence s_reload_fresh;
        tx_r == $past(vol_r);
    endsequence
    a_read_status_cmd_repeat: assert property (s_read_status_cmd_byte_end |=> s_reload_fresh)
        else $error("status byte not reloaded at byte end");
    a_read_status_cmd_volatile: assert property ($rose(state_r == ST_READ_STATUS_CMD) |-> s_reload_fresh)
        else $error("status read did not start from volatile copy");
    a_powerup_load: assert property (state_r == ST_LOAD |=> vol_r == $past(nv_r))
        else $error("volatile copy not loaded at power-up");
    a_latch_gate: assert property (cmd_r.valid && needs_latch(cmd_r.code)
        |-> $past(vol_r.write_enable_latch) || $past(vol_arm_r))
        else $error("write class accepted without latch");
    a_busy_filter: assert property (cmd_r.valid && $past(vol_r.busy_flag)
        |-> busy_ok(cmd_r.code) || cmd_r.code == CMD_SUSPEND_A
            || cmd_r.code == CMD_SUSPEND_B)
        else $error("instruction accepted while busy");
    a_latch_source: assert property ($rose(vol_r.write_enable_latch)
        |-> cmd_r.valid && cmd_r.code == CMD_WRITE_ENABLE)
        else $error("latch set by something other than write enable");
    a_vol_enable: assert property (cmd_r.valid && cmd_r.code == CMD_VOL_STATUS_ENABLE
        |-> vol_r.write_enable_latch == $past(vol_r.write_enable_latch))
        else $error("volatile enable changed the latch");
    a_done_clears: assert property (op_done && vol_r.busy_flag
        |=> !vol_r.write_enable_latch ##1 !vol_r.write_enable_latch)
        else $error("latch survived operation end");
    a_write_disable_cmd_clears: assert property (cmd_r.valid && cmd_r.code == CMD_WRITE_DISABLE
        |-> !vol_r.write_enable_latch)
        else $error("write disable left latch set");
    a_chip_erase: assert property (cmd_r.valid
        && (cmd_r.code == CMD_CHIP_ERASE_A || cmd_r.code == CMD_CHIP_ERASE_B)
        |-> $past(vol_r.block_protect) == 4'h0)
        else $error("chip erase accepted with protection set");
    a_lock_ignore: assert property (cmd_r.valid && cmd_r.code == CMD_WRITE_STATUS
        |-> !($past(vol_r.status_lock_bit) && !$past(wp_n_s)))
        else $error("status write accepted while locked");

endmodule : flash_status_write_enable_logic

// ==== dv/spi_host_model.sv ====
// Host controller model: serial frames out, status bytes back
`timescale 1ns/1ns
module spi_host_model (
    input wire logic clk,
    input wire logic so,
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic wp_n
);
    // Idle pins: clock still low, deselected, protect pin high
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        wp_n = 1'b1;
    end

    // Six fast cycles per half period of the 48 ns link clock
    task automatic half();
        repeat (6) @(posedge clk);
    endtask : half

    // One byte MSB first, mode 0; the answer is taken at each rise
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            si <= tx[i];
            half();
            sck <= 1'b1;
            rx[i] = so;
            half();
            sck <= 1'b0;
        end
    endtask : byte_io

    // One opcode per frame, then n whole bytes, two at most, in both directions
    task automatic frame(input logic [7:0] op, input int n, input logic [7:0] tx,
        output logic [7:0] rx0, output logic [7:0] rx1);
        logic [7:0] d;
        cs_n <= 1'b0;
        half();
        byte_io(op, d);
        if (n > 0)
            byte_io(tx, rx0);
        if (n > 1)
            byte_io(tx, rx1);
        half();
        cs_n <= 1'b1;
        si <= ~si; // Released line must not keep its last level
        repeat (12) @(posedge clk);
    endtask : frame
endmodule : spi_host_model

// ==== dv/flash_status_write_enable_logic_test.sv ====
// Bench for the status register pair and write enable gating
`timescale 1ns/1ns
module flash_status_write_enable_logic_test;
    import flash_status_pkg::*;
    logic clk;
    logic reset_n;
    logic op_done;
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
    logic so;
    logic so_oe_n;
    logic so_line;
    cmd_s cmd;
    status_s status;
    int err_total;
    int tests_run;
    int acc_cnt;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] gated [7] = '{8'h02, 8'h12, 8'hD8, 8'hC7, 8'h42, 8'hB5, 8'h7E};

    flash_status_write_enable_logic dut (.clk(clk), .reset_n(reset_n), .sck(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .op_done(op_done), .so(so), .so_oe_n(so_oe_n),
        .cmd(cmd), .status(status));
    spi_host_model host (.clk(clk), .so(so_line), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n));
    // Released output reads inverted, so a missing enable shows as wrong data
    assign so_line = so_oe_n ? ~so : so;

    // Clock and accepted-opcode counter
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (cmd.valid === 1'b1)
            acc_cnt <= acc_cnt + 1;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Frame with optional data byte; judges whether the opcode was taken
    task automatic acc(input logic [7:0] op, input logic ok, input int n = 0,
        input logic [7:0] d = 8'h00);
        int a;
        a = acc_cnt;
        host.frame(op, n, d, r0, r1);
        check("accepted", 8'(acc_cnt - a), {7'h00, ok});
        if (ok)
            check("code", cmd.code, op);
    endtask : acc

    task automatic done();
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : done

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("status", status, 8'h00);
        host.frame(CMD_READ_STATUS, 1, 8'h00, r0, r1);
        check("read", r0, 8'h00);
        foreach (gated[i]) acc(gated[i], 1'b0);
        acc(8'hC0, 1'b1);
    endtask : t_reset

    task automatic t_enable();
        acc(CMD_WRITE_ENABLE, 1'b1);
        check("latch set", status, 8'h02);
        host.frame(CMD_READ_STATUS, 2, 8'h00, r0, r1);
        check("byte0", r0, 8'h02);
        check("byte1", r1, 8'h02);
        check("released", {7'h00, so_oe_n}, 8'h01);
        acc(CMD_WRITE_DISABLE, 1'b1);
        check("latch clr", status, 8'h00);
        acc(CMD_VOL_STATUS_ENABLE, 1'b1);
        check("vol en", status, 8'h00);
        acc(CMD_WRITE_STATUS, 1'b1, 1, 8'h3F);
        check("vol wr", status, 8'h3C);
    endtask : t_enable

    task automatic t_busy();
        acc(CMD_WRITE_ENABLE, 1'b1);
        acc(CMD_CHIP_ERASE_A, 1'b0);
        acc(CMD_WRITE_STATUS, 1'b1, 1, 8'h00);
        check("busy", status, 8'h03);
        acc(CMD_WRITE_DISABLE, 1'b0);
        host.frame(CMD_READ_STATUS, 1, 8'h00, r0, r1);
        check("busy read", r0, 8'h03);
        done();
        check("op end", status, 8'h00);
        acc(CMD_WRITE_ENABLE, 1'b1);
        acc(8'h02, 1'b1);
        check("prog", status, 8'h03);
        acc(CMD_SUSPEND_A, 1'b1);
        done();
        check("prog end", {7'h00, status.busy_flag}, 8'h00);
    endtask : t_busy

    task automatic t_lock();
        acc(CMD_WRITE_ENABLE, 1'b1);
        acc(CMD_WRITE_STATUS, 1'b1, 1, 8'h80);
        done();
        check("lock", status, 8'h80);
        host.wp_n <= 1'b0;
        acc(CMD_WRITE_ENABLE, 1'b1);
        acc(CMD_WRITE_STATUS, 1'b0, 1, 8'h84);
        check("locked", status, 8'h82);
        host.wp_n <= 1'b1;
    endtask : t_lock

    // Chip erase with protection clear, then reads and suspend while busy
    task automatic t_erase();
        acc(CMD_CHIP_ERASE_B, 1'b1);
        check("erase", status, 8'h83);
        acc(CMD_READ_FUNCTION, 1'b1);
        acc(CMD_WRITE_ENABLE, 1'b0);
        acc(CMD_SUSPEND_B, 1'b1);
        done();
        check("erase end", status, 8'h80);
    endtask : t_erase

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // Watchdog at several times the few thousand cycles the frames take
    initial
    begin
        #100000;
        err_total++;
        final_report();
    end

    // Main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        acc_cnt = 0;
        reset_n = 1'b0;
        op_done = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_enable();
        t_busy();
        t_lock();
        t_erase();
        final_report();
    end
endmodule : flash_status_write_enable_logic_test
